// *** hdl/asx_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module asx_exec (
    // Clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    // Wake request, ends sleep
    input  wire logic        WAKE_I,
    // AXI4-Lite write
    input  wire logic [7:0]  AWADDR_I,
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    output logic [1:0]       BRESP_O,
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    // AXI4-Lite read
    input  wire logic [7:0]  ARADDR_I,
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    // Oscillator run, low while sleeping
    output logic             OSC_RUN_O,
    // Direction registers
    output logic [7:0]       DIR_A_O,
    output logic [7:0]       DIR_B_O,
    output logic [7:0]       DIR_C_O
);
    asx_alu_if alu_bus ();
    logic [15:0] wdog_count;

    // Architectural state
    logic [7:0] acc, next_acc;
    logic [7:0] file_reg [0:127];
    logic [4:0] status, next_status;
    logic [7:0] dir_a, dir_b, dir_c, next_dir_a, next_dir_b, next_dir_c;
    logic       sleeping, next_sleeping;
    logic       wr_file;
    logic [7:0] wr_file_val;
    logic       wdog_clear;
    // Bus state
    logic        aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0]  bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic        do_write;

    // Current command fields
    logic [3:0] cmd_op;
    logic [6:0] cmd_adr;
    logic [7:0] cmd_lit;
    logic       cmd_dst;
    logic [7:0] file_rd;

    assign do_write = aw_held && w_held && !bvalid;
    assign cmd_op   = w_data[asx_pkg::CMD_OP_LSB +: 4];
    assign cmd_adr  = w_data[asx_pkg::CMD_ADR_LSB +: 7];
    assign cmd_lit  = w_data[asx_pkg::CMD_LIT_LSB +: 8];
    assign cmd_dst  = w_data[asx_pkg::CMD_DST_BIT];
    assign file_rd  = file_reg[cmd_adr];

    // Operand select: literal ops use the immediate, others the file register
    assign alu_bus.op       = (do_write && aw_addr == asx_pkg::ADDR_CMD && !sleeping)
                              ? cmd_op : asx_pkg::OP_NONE;
    assign alu_bus.acc      = acc;
    assign alu_bus.opnd     = (cmd_op == asx_pkg::OP_SUBLIT || cmd_op == asx_pkg::OP_XORLIT)
                              ? cmd_lit : file_rd;
    assign alu_bus.carry_in = status[asx_pkg::ST_C];

    asx_alu u_alu (.port_a(alu_bus));

    asx_wdog u_wdog (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .clear_i (wdog_clear),
        .run_i   (1'b1),
        .count_o (wdog_count)
    );

    // AXI4-Lite channel handshakes: hold one address and one data word
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (AWVALID_I && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = AWADDR_I;
        end
        if (WVALID_I && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = WDATA_I;
            next_w_strb = WSTRB_I;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            case (aw_addr)
                asx_pkg::ADDR_CMD, asx_pkg::ADDR_ACC, asx_pkg::ADDR_STATUS,
                asx_pkg::ADDR_FILE, asx_pkg::ADDR_DIR, asx_pkg::ADDR_WDOG:
                    next_bresp = asx_pkg::RESP_OKAY;
                default: next_bresp = asx_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid && BREADY_I) begin
            next_bvalid = 1'b0;
        end
    end

    // Execution and software writes; a command while asleep is dropped
    always_comb begin
        next_acc      = acc;
        next_status   = status;
        next_dir_a    = dir_a;
        next_dir_b    = dir_b;
        next_dir_c    = dir_c;
        next_sleeping = sleeping;
        wr_file       = 1'b0;
        wr_file_val   = file_rd;
        wdog_clear    = 1'b0;
        if (sleeping && WAKE_I) next_sleeping = 1'b0;
        if (do_write && !sleeping) begin
            case (aw_addr)
                asx_pkg::ADDR_CMD: begin
                    case (cmd_op)
                        asx_pkg::OP_SUBLIT, asx_pkg::OP_XORLIT: begin
                            next_acc = alu_bus.result;
                            next_status[asx_pkg::ST_Z] = alu_bus.zero;
                            if (cmd_op == asx_pkg::OP_SUBLIT) begin
                                next_status[asx_pkg::ST_C]  = alu_bus.carry;
                                next_status[asx_pkg::ST_DC] = alu_bus.half;
                            end
                        end
                        asx_pkg::OP_SUBREG, asx_pkg::OP_SUBREGB,
                        asx_pkg::OP_NIBSWAP, asx_pkg::OP_XORREG: begin
                            if (cmd_dst) begin
                                wr_file     = 1'b1;
                                wr_file_val = alu_bus.result;
                            end else begin
                                next_acc = alu_bus.result;
                            end
                            if (cmd_op != asx_pkg::OP_NIBSWAP)
                                next_status[asx_pkg::ST_Z] = alu_bus.zero;
                            if (cmd_op == asx_pkg::OP_SUBREG || cmd_op == asx_pkg::OP_SUBREGB) begin
                                next_status[asx_pkg::ST_C]  = alu_bus.carry;
                                next_status[asx_pkg::ST_DC] = alu_bus.half;
                            end
                        end
                        asx_pkg::OP_DIRLOAD: begin
                            case (cmd_adr)
                                asx_pkg::DIR_SEL_A: next_dir_a = acc;
                                asx_pkg::DIR_SEL_B: next_dir_b = acc;
                                asx_pkg::DIR_SEL_C: next_dir_c = acc;
                                default: next_dir_a = dir_a;
                            endcase
                        end
                        asx_pkg::OP_SLEEP: begin
                            next_status[asx_pkg::ST_PD] = 1'b0;
                            next_status[asx_pkg::ST_TO] = 1'b1;
                            wdog_clear    = 1'b1;
                            next_sleeping = 1'b1;
                        end
                        default: next_acc = acc;
                    endcase
                end
                asx_pkg::ADDR_ACC: if (w_strb[0]) next_acc = w_data[7:0];
                asx_pkg::ADDR_STATUS: if (w_strb[0]) next_status = w_data[4:0];
                asx_pkg::ADDR_FILE: if (w_strb[0]) begin
                    wr_file     = 1'b1;
                    wr_file_val = w_data[7:0];
                end
                default: next_acc = acc;
            endcase
        end
    end

    // Read channel; file window reads the location last named in the command field
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (ARVALID_I && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = asx_pkg::RESP_OKAY;
            case (ARADDR_I)
                asx_pkg::ADDR_CMD:    next_rdata = w_data;
                asx_pkg::ADDR_ACC:    next_rdata = {24'h000000, acc};
                asx_pkg::ADDR_STATUS: next_rdata = {26'h0000000, sleeping, status};
                asx_pkg::ADDR_FILE:   next_rdata = {24'h000000, file_rd};
                asx_pkg::ADDR_DIR:    next_rdata = {8'h00, dir_c, dir_b, dir_a};
                asx_pkg::ADDR_WDOG:   next_rdata = {16'h0000, wdog_count};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = asx_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && RREADY_I) begin
            next_rvalid = 1'b0;
        end
    end

    // File memory is written without reset; it is plain data storage
    always_ff @(posedge MCLK_I) begin
        if (wr_file) file_reg[cmd_adr] <= wr_file_val;
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_held <= 1'b0;  aw_addr <= 8'h00;
            w_held  <= 1'b0;  w_data  <= 32'h00000000;  w_strb <= 4'h0;
            bvalid  <= 1'b0;  bresp   <= 2'h0;
            rvalid  <= 1'b0;  rresp   <= 2'h0;  rdata  <= 32'h00000000;
            acc     <= 8'h00; status  <= asx_pkg::STATUS_RST;
            dir_a   <= asx_pkg::DIR_RST; dir_b <= asx_pkg::DIR_RST; dir_c <= asx_pkg::DIR_RST;
            sleeping <= 1'b0;
        end else begin
            aw_held <= next_aw_held;  aw_addr <= next_aw_addr;
            w_held  <= next_w_held;   w_data  <= next_w_data;  w_strb <= next_w_strb;
            bvalid  <= next_bvalid;   bresp   <= next_bresp;
            rvalid  <= next_rvalid;   rresp   <= next_rresp;  rdata  <= next_rdata;
            acc     <= next_acc;      status  <= next_status;
            dir_a   <= next_dir_a;    dir_b   <= next_dir_b;  dir_c  <= next_dir_c;
            sleeping <= next_sleeping;
        end
    end

    // Ready only while the holding slot is empty, so outputs stay registered
    always_comb begin
        AWREADY_O = !aw_held;
        WREADY_O  = !w_held;
        ARREADY_O = !rvalid;
    end
    assign BVALID_O  = bvalid;
    assign BRESP_O   = bresp;
    assign RVALID_O  = rvalid;
    assign RDATA_O   = rdata;
    assign RRESP_O   = rresp;
    assign OSC_RUN_O = !sleeping;
    assign DIR_A_O   = dir_a;
    assign DIR_B_O   = dir_b;
    assign DIR_C_O   = dir_c;

    property p_sleep;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_SLEEP) |=> (!OSC_RUN_O && !status[asx_pkg::ST_PD]
                                               && status[asx_pkg::ST_TO]);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
    property p_sleep_keep;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_SLEEP) |=> $stable(status[2:0]) && $stable(acc);
    endproperty
    a_sleep_keep: assert property (p_sleep_keep) else $error("sleep touched flags");
    property p_osc;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_SLEEP) ##1 !WAKE_I |=> !OSC_RUN_O;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator resumed");
    property p_sublit;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_SUBLIT) |=> acc == 8'(cmd_lit - $past(acc))
            && status[asx_pkg::ST_C] == ($past(acc) <= cmd_lit);
    endproperty
    a_sublit: assert property (p_sublit) else $error("literal subtract wrong");
    property p_half;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_SUBLIT)
            |=> status[asx_pkg::ST_DC] == ($past(acc[3:0]) <= cmd_lit[3:0]);
    endproperty
    a_half: assert property (p_half) else $error("nibble flag wrong");
    property p_zero;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_XORLIT) |=> status[asx_pkg::ST_Z] == (acc == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_xor_flags;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_XORREG) |=> $stable(status[1:0]);
    endproperty
    a_xor_flags: assert property (p_xor_flags) else $error("xor touched carry");
    property p_swap;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_NIBSWAP && !cmd_dst)
            |=> acc == {$past(file_rd[3:0]), $past(file_rd[7:4])} && $stable(status);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");
    property p_dst;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_XORREG && cmd_dst) |=> $stable(acc);
    endproperty
    a_dst: assert property (p_dst) else $error("destination ignored");
    property p_dir;
        @(posedge MCLK_I) disable iff (RST_I)
        (alu_bus.op == asx_pkg::OP_DIRLOAD && cmd_adr == asx_pkg::DIR_SEL_B)
            |=> DIR_B_O == $past(acc) && $stable(status);
    endproperty
    a_dir: assert property (p_dir) else $error("direction load wrong");
endmodule : asx_exec
`default_nettype wire

// *** hdl/asx_pkg.sv ***
// Summary of operation
// - literal_minus_acc writes immediate minus accumulator into the accumulator.
// - Subtraction carry clear when subtrahend exceeds minuend; nibble flag likewise; zero updates.
// - Power-down clears power_down_flag, sets expiry_flag, touches no other status bit.
// - Power-down zeroes the watchdog_counter and clears its prescaler.
// - After power-down the core sleeps with the main oscillator halted.
// - reg_minus_acc subtracts accumulator from addressed register, updating carry, nibble, zero.
// - reg_minus_acc_borrow also subtracts the inverted carry; updates carry, nibble, zero.
// - Destination bit 0 writes accumulator, 1 writes back to the file register.
// - nibble_exchange swaps register nibbles into the result; no flag changes.
// - direction_load_op copies accumulator to port A, B or C direction for 5, 6, 7.
// - literal_xor_acc XORs accumulator with immediate into accumulator; only zero updates.
// - reg_xor_acc XORs accumulator with register, routed by destination; only zero updates.
package asx_pkg;
    // Operation codes presented by the sequencer
    localparam logic [3:0] OP_NONE      = 4'h0;
    localparam logic [3:0] OP_SUBLIT    = 4'h1;
    localparam logic [3:0] OP_SUBREG    = 4'h2;
    localparam logic [3:0] OP_SUBREGB   = 4'h3;
    localparam logic [3:0] OP_NIBSWAP   = 4'h4;
    localparam logic [3:0] OP_DIRLOAD   = 4'h5;
    localparam logic [3:0] OP_XORLIT    = 4'h6;
    localparam logic [3:0] OP_XORREG    = 4'h7;
    localparam logic [3:0] OP_SLEEP     = 4'h8;
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CMD     = 8'h00;
    localparam logic [7:0] ADDR_ACC     = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_FILE    = 8'h0c;
    localparam logic [7:0] ADDR_DIR     = 8'h10;
    localparam logic [7:0] ADDR_WDOG    = 8'h14;
    // Command word fields
    localparam int CMD_LIT_LSB  = 0;
    localparam int CMD_ADR_LSB  = 8;
    localparam int CMD_DST_BIT  = 15;
    localparam int CMD_OP_LSB   = 16;
    // Status fields
    localparam int ST_C   = 0;
    localparam int ST_DC  = 1;
    localparam int ST_Z   = 2;
    localparam int ST_PD  = 3;
    localparam int ST_TO  = 4;
    localparam int ST_SLP = 5;
    localparam logic [4:0] STATUS_RST = 5'h18;
    localparam logic [7:0] DIR_RST    = 8'hff;
    // Direction-load operand values
    localparam logic [6:0] DIR_SEL_A = 7'h05;
    localparam logic [6:0] DIR_SEL_B = 7'h06;
    localparam logic [6:0] DIR_SEL_C = 7'h07;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : asx_pkg

// *** hdl/asx_alu_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operand and result bundle between sequencer and arithmetic unit
interface asx_alu_if;
    logic [3:0] op;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic       carry_in;
    logic [7:0] result;
    logic       carry;
    logic       half;
    logic       zero;
    modport seq (output op, acc, opnd, carry_in, input result, carry, half, zero);
    modport alu (input op, acc, opnd, carry_in, output result, carry, half, zero);
endinterface : asx_alu_if
`default_nettype wire

// *** hdl/asx_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module asx_alu (
    asx_alu_if.alu port_a
);
    // Subtract b and borrow from a; returns carry(no-borrow), half, result
    function automatic logic [9:0] asx_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic bw);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} - {1'b0, b} - {8'h00, bw};
        low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
        return {~full[8], ~low[4], full[7:0]};
    endfunction : asx_sub

    logic [9:0] sub_res;

    // Combinational datapath; flags are only used where the op affects them
    always_comb begin
        sub_res = 10'h000;
        port_a.result = 8'h00;
        port_a.carry  = 1'b0;
        port_a.half   = 1'b0;
        case (port_a.op)
            asx_pkg::OP_SUBLIT: sub_res = asx_sub(port_a.opnd, port_a.acc, 1'b0);
            asx_pkg::OP_SUBREG: sub_res = asx_sub(port_a.opnd, port_a.acc, 1'b0);
            asx_pkg::OP_SUBREGB: sub_res = asx_sub(port_a.opnd, port_a.acc, ~port_a.carry_in);
            default: sub_res = 10'h000;
        endcase
        case (port_a.op)
            asx_pkg::OP_SUBLIT, asx_pkg::OP_SUBREG, asx_pkg::OP_SUBREGB: begin
                port_a.result = sub_res[7:0];
                port_a.carry  = sub_res[9];
                port_a.half   = sub_res[8];
            end
            asx_pkg::OP_NIBSWAP: port_a.result = {port_a.opnd[3:0], port_a.opnd[7:4]};
            asx_pkg::OP_XORLIT, asx_pkg::OP_XORREG: port_a.result = port_a.acc ^ port_a.opnd;
            default: port_a.result = 8'h00;
        endcase
        port_a.zero = (port_a.result == 8'h00);
    end
endmodule : asx_alu
`default_nettype wire

// *** hdl/asx_wdog.sv ***
`timescale 1ns/1ps
`default_nettype none
module asx_wdog #(
    parameter int WIDTH = 16,
    parameter int PRE_WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             clear_i,
    input  wire logic             run_i,
    output logic      [WIDTH-1:0] count_o
);
    logic [PRE_WIDTH-1:0] pre;
    logic [PRE_WIDTH-1:0] next_pre;
    logic [WIDTH-1:0]     next_count;

    // Prescaler and counter both cleared by power-down
    always_comb begin
        next_pre = pre;
        next_count = count_o;
        if (clear_i) begin
            next_pre = '0;
            next_count = '0;
        end else if (run_i) begin
            next_pre = pre + 1'b1;
            if (pre == '1) next_count = count_o + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre <= '0;
            count_o <= '0;
        end else begin
            pre <= next_pre;
            count_o <= next_count;
        end
    end

    property p_clear;
        @(posedge clk_i) disable iff (rst_i) clear_i |=> (count_o == '0 && pre == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("watchdog not cleared");
endmodule : asx_wdog
`default_nettype wire

// *** verif/asx_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Register bus master standing in for the instruction sequencer
module asx_host_model (
    // Clock
    input  wire logic        clk_i,
    // Write channels
    output logic      [7:0]  awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic      [31:0] wdata_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    // Read channels
    output logic      [7:0]  araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o,
    // Raised when the slave never answers
    output logic             tmo_o
);
    localparam int LIMIT = 200;
    // Idle bus at time zero
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o, tmo_o} = '0;
    end
    // Write: each channel dropped at its own handshake; released lines are inverted
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            {awaddr_o, wdata_o} <= {a, d};
            {awvalid_o, wvalid_o, bready_o} <= 3'h7;
            do begin
                @(posedge clk_i);
                n++;
                if (awvalid_o && awready_i) begin
                    awvalid_o <= 1'b0;
                    awaddr_o  <= ~a;
                end
                if (wvalid_o && wready_i) begin
                    wvalid_o <= 1'b0;
                    wdata_o  <= ~d;
                end
            end while (!(bvalid_i && bready_o) && n < LIMIT);
            r = bresp_i;
            bready_o <= 1'b0;
            if (!bvalid_i) tmo_o <= 1'b1;
        end
    endtask : wr
    // Read: address held until taken, rready held until the answer
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            araddr_o <= a;
            {arvalid_o, rready_o} <= 2'h3;
            do begin
                @(posedge clk_i);
                n++;
                if (arvalid_o && arready_i) begin
                    arvalid_o <= 1'b0;
                    araddr_o  <= ~a;
                end
            end while (!(rvalid_i && rready_o) && n < LIMIT);
            {d, r} = {rdata_i, rresp_i};
            rready_o <= 1'b0;
            if (!rvalid_i) tmo_o <= 1'b1;
        end
    endtask : rd
endmodule : asx_host_model
`default_nettype wire

// *** verif/alu_subtract_xor_swap_exec_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// Bus-driven bench with an integer reference of the datapath
module alu_subtract_xor_swap_exec_test;
    logic        mclk, rst, wake, osc_run, tmo;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr, dir_a, dir_b, dir_c;
    logic [31:0] wdata, rdata, rs;
    logic [1:0]  bresp, rresp;
    // Reference state
    logic [7:0]  acc, fv, lit, dira, dirb, dirc;
    logic [6:0]  fa;
    logic [3:0]  op;
    logic        dst, c, dc, z, pd, to, slp;
    int          res, err_total, n_compared;

    asx_exec i_dut (.MCLK_I(mclk), .RST_I(rst), .WAKE_I(wake), .AWADDR_I(awaddr),
        .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf),
        .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
        .OSC_RUN_O(osc_run), .DIR_A_O(dir_a), .DIR_B_O(dir_b), .DIR_C_O(dir_c));
    asx_host_model i_host (.clk_i(mclk), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
        .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
        .rvalid_i(rvalid), .rready_o(rready), .tmo_o(tmo));

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction : lfsr
    function automatic logic [31:0] stat();
        stat = {26'h0, slp, to, pd, z, dc, c};
    endfunction : stat
    task automatic give_verdict;
        begin
            $display("compared %0d, mismatches %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_compared++;
            if (seen !== exp) begin
                err_total++;
                $display("wrong value %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        begin
            i_host.wr(a, d, r);
            chk("write answer", {30'h0, r}, {30'h0, er});
        end
    endtask : wreg
    // Data compared only where an OKAY answer is expected
    task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        begin
            i_host.rd(a, d, r);
            chk("read answer", {30'h0, r}, {30'h0, er});
            if (er == asx_pkg::RESP_OKAY) chk(nm, d, e);
        end
    endtask : rreg
    // Subtraction with borrow b; carry means no borrow out
    task automatic sub(input logic [7:0] m, input int b);
        int r;
        begin
            r = int'(m) - int'(acc) - b;
            c = (r >= 0);
            dc = (int'(m[3:0]) - int'(acc[3:0]) - b) >= 0;
            res = r & 255;
            z = (res == 0);
        end
    endtask : sub
    // Reference execution of one command
    task automatic exec;
        begin
            res = -1;
            case (op)
                4'h1: sub(lit, 0);
                4'h2: sub(fv, 0);
                4'h3: sub(fv, c ? 0 : 1);
                4'h4: res = {fv[3:0], fv[7:4]};
                4'h5: begin
                    if (fa == 7'h05) dira = acc;
                    if (fa == 7'h06) dirb = acc;
                    if (fa == 7'h07) dirc = acc;
                end
                4'h6: res = acc ^ lit;
                default: res = acc ^ fv;
            endcase
            if (op == 4'h6 || op == 4'h7) z = (res == 0);
            // Literal forms ignore the destination bit
            if (res >= 0 && (!dst || op == 4'h1 || op == 4'h6)) acc = res[7:0];
            else if (res >= 0) fv = res[7:0];
        end
    endtask : exec

    // A hung handshake or an overlong run ends in the closing report
    always @(posedge tmo) begin
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        give_verdict();
    end

    initial begin
        {err_total, n_compared, wake, rst, rs} = {32'h0, 32'h0, 2'b01, 32'h6c694921};
        {acc, dira, dirb, dirc, c, dc, z, pd, to, slp} = {8'h0, 24'hffffff, 6'b000110};
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rreg("status", asx_pkg::ADDR_STATUS, stat(), asx_pkg::RESP_OKAY);
        // Operations 1 to 7, random operands, every direction selector
        for (int i = 0; i < 84; i++) begin
            op = 4'(1 + i % 7);
            rs = lfsr(rs);
            fa = (op == 4'h5) ? 7'(4 + (i / 7) % 4) : rs[14:8];
            {dst, lit} = {rs[15], rs[7:0]};
            rs = lfsr(rs);
            {acc, fv} = rs[15:0];
            wreg(asx_pkg::ADDR_CMD, {17'h0, fa, 8'h00}, asx_pkg::RESP_OKAY);
            wreg(asx_pkg::ADDR_FILE, {17'h0, fa, fv}, asx_pkg::RESP_OKAY);
            wreg(asx_pkg::ADDR_ACC, {24'h0, acc}, asx_pkg::RESP_OKAY);
            wreg(asx_pkg::ADDR_CMD, {12'h0, op, dst, fa, lit}, asx_pkg::RESP_OKAY);
            exec();
            rreg("acc", asx_pkg::ADDR_ACC, acc, asx_pkg::RESP_OKAY);
            rreg("status", asx_pkg::ADDR_STATUS, stat(), asx_pkg::RESP_OKAY);
            rreg("file", asx_pkg::ADDR_FILE, fv, asx_pkg::RESP_OKAY);
            chk("dirs", {8'h0, dir_a, dir_b, dir_c}, {8'h0, dira, dirb, dirc});
        end
        // Power-down: flags, watchdog, oscillator, writes ignored, then wake
        wreg(asx_pkg::ADDR_CMD, 32'h00080000, asx_pkg::RESP_OKAY);
        {pd, to, slp} = 3'b011;
        chk("osc run", {31'h0, osc_run}, 32'h0);
        rreg("status", asx_pkg::ADDR_STATUS, stat(), asx_pkg::RESP_OKAY);
        rreg("watchdog", asx_pkg::ADDR_WDOG, 32'h0, asx_pkg::RESP_OKAY);
        wreg(asx_pkg::ADDR_ACC, 32'h5a, asx_pkg::RESP_OKAY);
        rreg("acc", asx_pkg::ADDR_ACC, acc, asx_pkg::RESP_OKAY);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        repeat (3) @(posedge mclk);
        slp = 1'b0;
        chk("osc run", {31'h0, osc_run}, 32'h1);
        rreg("status", asx_pkg::ADDR_STATUS, stat(), asx_pkg::RESP_OKAY);
        // Unmapped places are refused
        rreg("unmapped", 8'h18, 32'h0, asx_pkg::RESP_SLVERR);
        wreg(8'h1c, 32'h1, asx_pkg::RESP_SLVERR);
        give_verdict();
    end
endmodule : alu_subtract_xor_swap_exec_test
`default_nettype wire
